// File: one_wire_link_params.svh
// Timing constants for the single-wire host link and the bus-reset watchdogs
`ifndef ONE_WIRE_LINK_PARAMS_SVH
`define ONE_WIRE_LINK_PARAMS_SVH

`define OW_CLK_MHZ 10
`define OW_CYC_CEIL(t_us) (int'($ceil((t_us) * `OW_CLK_MHZ)))
`define OW_CYC_FLOOR(t_us) (int'($floor((t_us) * `OW_CLK_MHZ)))

// Host-driven timing, microseconds
`define OW_BREAK_LOW_US 190
`define OW_BREAK_RECOVERY_US 40
`define OW_HOST_ONE_MIN_US 0.5
`define OW_HOST_ONE_MAX_US 50
`define OW_HOST_ZERO_MIN_US 86
`define OW_HOST_ZERO_MAX_US 145
`define OW_HOST_SLOT_MIN_US 190
`define OW_HOST_TURNAROUND_US 210

// Device-driven timing, microseconds
`define OW_DEV_SLOT_MIN_US 190
`define OW_DEV_SLOT_NOM_US 205
`define OW_DEV_SLOT_MAX_US 250
`define OW_DEV_ONE_MIN_US 32
`define OW_DEV_ONE_NOM_US 40
`define OW_DEV_ONE_MAX_US 50
`define OW_DEV_ZERO_MIN_US 80
`define OW_DEV_ZERO_NOM_US 112
`define OW_DEV_ZERO_MAX_US 145
`define OW_RESPONSE_MIN_US 190

// Bus reset by a long low, seconds
`define OW_BUS_RESET_MIN_S 1.9
`define OW_BUS_RESET_MAX_S 2.1

// Cycle counts at the system clock
`define OW_BREAK_CYC `OW_CYC_CEIL(`OW_BREAK_LOW_US)
`define OW_HOST_ONE_MIN_CYC `OW_CYC_CEIL(`OW_HOST_ONE_MIN_US)
`define OW_HOST_ONE_MAX_CYC `OW_CYC_FLOOR(`OW_HOST_ONE_MAX_US)
`define OW_HOST_ZERO_MIN_CYC `OW_CYC_CEIL(`OW_HOST_ZERO_MIN_US)
`define OW_DEV_SLOT_CYC `OW_CYC_CEIL(`OW_DEV_SLOT_NOM_US)
`define OW_DEV_SLOT_MIN_CYC `OW_CYC_CEIL(`OW_DEV_SLOT_MIN_US)
`define OW_DEV_SLOT_MAX_CYC `OW_CYC_FLOOR(`OW_DEV_SLOT_MAX_US)
`define OW_DEV_ONE_CYC `OW_CYC_CEIL(`OW_DEV_ONE_NOM_US)
`define OW_DEV_ONE_MIN_CYC `OW_CYC_CEIL(`OW_DEV_ONE_MIN_US)
`define OW_DEV_ONE_MAX_CYC `OW_CYC_FLOOR(`OW_DEV_ONE_MAX_US)
`define OW_DEV_ZERO_CYC `OW_CYC_CEIL(`OW_DEV_ZERO_NOM_US)
`define OW_DEV_ZERO_MIN_CYC `OW_CYC_CEIL(`OW_DEV_ZERO_MIN_US)
`define OW_DEV_ZERO_MAX_CYC `OW_CYC_FLOOR(`OW_DEV_ZERO_MAX_US)
`define OW_RESPONSE_CYC `OW_CYC_CEIL(`OW_RESPONSE_MIN_US)
`define OW_BUS_RESET_CYC `OW_CYC_CEIL(`OW_BUS_RESET_MIN_S * 1.0E6)

`endif

// File: one_wire_link_pkg.sv
// Types shared by the single-wire host link files
package one_wire_link_pkg;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_LOW  = 2'b01,
      TX_HIGH = 2'b10
   } tx_state_t;

   typedef struct packed {
      logic is_break;
      logic value;
   } rx_word_t;

endpackage

// File: two_entry_buffer.sv
// Small valid/ready buffer between the bit decoder and its consumer
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
   parameter int unsigned WIDTH = 2,
   parameter int unsigned DEPTH = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic flush_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
   localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] count_r;

   wire do_wr = in_valid_i & in_ready_o;
   wire do_rd = out_valid_o & out_ready_i;
   wire [PW-1:0] wr_ptr_nxt = (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
   wire [PW-1:0] rd_ptr_nxt = (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;

   // Full refuses the writer; the block upstream flags the loss
   assign in_ready_o = (count_r != DEPTH_C);
   assign out_valid_o = (count_r != '0);
   assign out_data_o = mem_r[rd_ptr_r];

   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (flush_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= wr_ptr_nxt;
         end
         if (do_rd) begin
            rd_ptr_r <= rd_ptr_nxt;
         end
         if (do_wr && !do_rd) begin
            count_r <= count_r + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// File: one_wire_host_link.sv
// Bit-level timing of the single-wire host link plus long-low bus-reset watchdogs
`timescale 1ns/1ps
`include "one_wire_link_params.svh"
`default_nettype none

// Summary of operation
// - Device bit slot lasts 190 to 250 us.
// - Device one pulls low 32 to 50 us.
// - Device zero pulls low 80 to 145 us.
// - Device waits 190 us before first reply bit.
// - Line low about two seconds resets link.
// - Clock low about two seconds resets serial bus.
module one_wire_host_link #(
   parameter int unsigned RESET_LOW_CYC = `OW_BUS_RESET_CYC
) (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   // Single-wire host line, open drain
   input wire logic LINE_I,
   output logic LINE_O,
   output logic LINE_OE_O,
   // Two-wire serial bus clock, watched only
   input wire logic SCL_I,
   // Bits to send to the host
   input wire logic TX_VALID_I,
   input wire logic TX_BIT_I,
   output logic TX_READY_O,
   // Bits and breaks received from the host
   output logic RX_VALID_O,
   output var one_wire_link_pkg::rx_word_t RX_WORD_O,
   input wire logic RX_READY_I,
   output logic RX_OVERRUN_O,
   // Interface reset pulses
   output logic LINK_RESET_O,
   output logic SERIAL_RESET_O
);
   localparam int unsigned CW = 25;
   localparam int unsigned TW = 12;
   localparam logic [CW-1:0] RST_C = CW'(RESET_LOW_CYC);
   localparam logic [CW-1:0] BREAK_C = CW'(`OW_BREAK_CYC);
   localparam logic [CW-1:0] ONE_MIN_C = CW'(`OW_HOST_ONE_MIN_CYC);
   localparam logic [CW-1:0] ONE_MAX_C = CW'(`OW_HOST_ONE_MAX_CYC);
   localparam logic [CW-1:0] ZERO_MIN_C = CW'(`OW_HOST_ZERO_MIN_CYC);
   localparam logic [TW-1:0] RSPS_C = TW'(`OW_RESPONSE_CYC);
   localparam logic [TW-1:0] SLOT_C = TW'(`OW_DEV_SLOT_CYC);
   localparam logic [TW-1:0] DONE_C = TW'(`OW_DEV_ONE_CYC);
   localparam logic [TW-1:0] DZERO_C = TW'(`OW_DEV_ZERO_CYC);

   // Synchronisers and line history
   logic line_s1_r, line_s2_r, line_prev_r;
   logic scl_s1_r, scl_s2_r;
   logic [CW-1:0] low_cnt_r, scl_low_cnt_r;
   logic [TW-1:0] idle_cnt_r;

   // Transmit state
   one_wire_link_pkg::tx_state_t tx_state_r, tx_state_nxt;
   logic [TW-1:0] tx_cnt_r, tx_cnt_nxt;
   logic tx_bit_r, dev_last_r;
   logic link_reset_r, serial_reset_r, overrun_r;

   // Line edges; only the second synchroniser stage is looked at
   wire line_rise = line_s2_r & ~line_prev_r;
   wire line_fall = ~line_s2_r & line_prev_r;
   wire tx_busy = (tx_state_r != one_wire_link_pkg::TX_IDLE);

   // Long-low detection, fires once per low period
   wire link_hit = ~line_s2_r & (low_cnt_r == RST_C - 1'b1);
   wire serial_hit = ~scl_s2_r & (scl_low_cnt_r == RST_C - 1'b1);

   // Host bit decode by low width at the rising edge
   wire rx_event = line_rise & ~tx_busy;
   wire is_one = (low_cnt_r >= ONE_MIN_C) & (low_cnt_r <= ONE_MAX_C);
   wire is_zero = (low_cnt_r >= ZERO_MIN_C) & (low_cnt_r < BREAK_C);
   wire is_break = (low_cnt_r >= BREAK_C);
   wire rx_push = rx_event & (is_one | is_zero | is_break);
   wire buf_ready;
   one_wire_link_pkg::rx_word_t rx_word;
   // One driver for the whole word; break flag sits above the bit value
   assign rx_word = one_wire_link_pkg::rx_word_t'({is_break, is_one});

   // Reply may start after the response gap, or straight after an own slot
   wire gap_met = dev_last_r | (idle_cnt_r >= RSPS_C);
   wire tx_start = TX_VALID_I & TX_READY_O;
   wire [TW-1:0] pulse_end = tx_bit_r ? DONE_C : DZERO_C;

   assign TX_READY_O = ~tx_busy & line_s2_r & gap_met & ~link_reset_r;
   assign LINE_O = 1'b0;
   assign LINE_OE_O = (tx_state_r == one_wire_link_pkg::TX_LOW);
   assign LINK_RESET_O = link_reset_r;
   assign SERIAL_RESET_O = serial_reset_r;
   assign RX_OVERRUN_O = overrun_r;

   always_comb begin
      tx_state_nxt = tx_state_r;
      tx_cnt_nxt = tx_cnt_r + 1'b1;
      unique case (tx_state_r)
         one_wire_link_pkg::TX_IDLE: begin
            tx_cnt_nxt = '0;
            if (tx_start) begin
               tx_state_nxt = one_wire_link_pkg::TX_LOW;
            end
         end
         one_wire_link_pkg::TX_LOW: begin
            if (tx_cnt_r == pulse_end - 1'b1) begin
               tx_state_nxt = one_wire_link_pkg::TX_HIGH;
            end
         end
         one_wire_link_pkg::TX_HIGH: begin
            if (tx_cnt_r == SLOT_C - 1'b1) begin
               tx_state_nxt = one_wire_link_pkg::TX_IDLE;
            end
         end
         default: begin
            tx_state_nxt = one_wire_link_pkg::TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         line_s1_r <= 1'b1;
         line_s2_r <= 1'b1;
         line_prev_r <= 1'b1;
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
      end else begin
         line_s1_r <= LINE_I;
         line_s2_r <= line_s1_r;
         line_prev_r <= line_s2_r;
         scl_s1_r <= SCL_I;
         scl_s2_r <= scl_s1_r;
      end
   end

   // Saturating low and idle timers; saturation keeps a stuck line from re-firing
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         low_cnt_r <= '0;
         scl_low_cnt_r <= '0;
         idle_cnt_r <= '0;
      end else begin
         low_cnt_r <= line_s2_r ? '0 : low_cnt_r + CW'(low_cnt_r != '1);
         scl_low_cnt_r <= scl_s2_r ? '0 : scl_low_cnt_r + CW'(scl_low_cnt_r != '1);
         idle_cnt_r <= line_s2_r ? idle_cnt_r + TW'(idle_cnt_r != '1) : '0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         link_reset_r <= 1'b0;
         serial_reset_r <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         link_reset_r <= link_hit;
         serial_reset_r <= serial_hit;
         overrun_r <= rx_push & ~buf_ready;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         tx_state_r <= one_wire_link_pkg::TX_IDLE;
         tx_cnt_r <= '0;
         tx_bit_r <= 1'b0;
         dev_last_r <= 1'b0;
      end else if (link_reset_r) begin
         tx_state_r <= one_wire_link_pkg::TX_IDLE;
         tx_cnt_r <= '0;
         dev_last_r <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         if (tx_start) begin
            tx_bit_r <= TX_BIT_I;
         end
         if (tx_busy && tx_state_nxt == one_wire_link_pkg::TX_IDLE) begin
            dev_last_r <= 1'b1;
         end else if (line_fall && !tx_busy) begin
            dev_last_r <= 1'b0;
         end
      end
   end

   two_entry_buffer #(
      .WIDTH($bits(one_wire_link_pkg::rx_word_t)),
      .DEPTH(2)
   ) rx_buf (
      .clk_i(SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .flush_i(link_reset_r),
      .in_valid_i(rx_push),
      .in_data_i(rx_word),
      .in_ready_o(buf_ready),
      .out_valid_o(RX_VALID_O),
      .out_data_o(RX_WORD_O),
      .out_ready_i(RX_READY_I)
   );

   // Checking helpers
   logic [TW-1:0] oe_len_r, slot_len_r;
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         oe_len_r <= '0;
         slot_len_r <= '0;
      end else begin
         oe_len_r <= LINE_OE_O ? oe_len_r + 1'b1 : '0;
         slot_len_r <= tx_busy ? slot_len_r + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);

   a_one_pulse_width: assert property ($fell(LINE_OE_O) && tx_bit_r |->
      oe_len_r >= TW'(`OW_DEV_ONE_MIN_CYC) && oe_len_r <= TW'(`OW_DEV_ONE_MAX_CYC))
      else $error("device one pulse width out of range");
   a_zero_pulse_width: assert property ($fell(LINE_OE_O) && !tx_bit_r |->
      oe_len_r >= TW'(`OW_DEV_ZERO_MIN_CYC) && oe_len_r <= TW'(`OW_DEV_ZERO_MAX_CYC))
      else $error("device zero pulse width out of range");
   a_slot_length: assert property (tx_busy && !link_reset_r ##1 !tx_busy |->
      $past(slot_len_r) >= TW'(`OW_DEV_SLOT_MIN_CYC) - 1'b1 && $past(slot_len_r) < TW'(`OW_DEV_SLOT_MAX_CYC))
      else $error("device bit slot length out of range");
   a_response_gap: assert property ($rose(LINE_OE_O) |->
      $past(dev_last_r) || $past(idle_cnt_r) >= RSPS_C)
      else $error("device reply started too early");
   a_link_reset: assert property (LINK_RESET_O |-> $past(low_cnt_r) == RST_C - 1'b1
      ##1 (tx_state_r == one_wire_link_pkg::TX_IDLE && !LINE_OE_O && !RX_VALID_O))
      else $error("link reset did not clear the interface");
   a_serial_reset: assert property ($past(scl_low_cnt_r) == RST_C - 1'b1 && !$past(scl_s2_r)
      |-> SERIAL_RESET_O ##1 !SERIAL_RESET_O)
      else $error("serial bus reset pulse missing");
   a_decode_width: assert property (rx_push && !rx_word.is_break |->
      (rx_word.value ? low_cnt_r <= ONE_MAX_C : low_cnt_r >= ZERO_MIN_C))
      else $error("host bit decoded from wrong width");
   a_release_rest: assert property ($rose(LINE_OE_O) |-> $past(line_s2_r)
      ##1 LINE_OE_O [*8])
      else $error("device slot not begun by a held falling edge");

   c_send_one: cover property ($fell(LINE_OE_O) && tx_bit_r);
   c_send_zero: cover property ($fell(LINE_OE_O) && !tx_bit_r);
   c_rx_break: cover property (rx_push && is_break);
   c_rx_overrun: cover property (RX_OVERRUN_O);

endmodule

`default_nettype wire

// File: one_wire_host_model.sv
// Host-side partner: open-drain line with pull-up, serial clock and an edge monitor
`timescale 1ns/1ps
`default_nettype none
module one_wire_host_model (
   // Clock
   input wire logic clk_i,
   // Device drive of the line
   input wire logic dev_oe_i,
   input wire logic dev_o_i,
   // Wire levels seen by everyone
   output logic line_o,
   output logic scl_o
);
   logic host_low = 1'b0;
   logic prev_line = 1'b1;
   logic dev_drv = 1'b0;
   int cyc = 0;
   int fall_cyc = 0;
   int host_rise = 0;
   int dev_rise = -100000;
   int dev_low_q[$];
   int dev_fall_q[$];
   initial scl_o = 1'b1;
   // Pull-up wins whenever nobody pulls low, so a released line never keeps a stale level
   assign line_o = (host_low || (dev_oe_i && !dev_o_i)) ? 1'b0 : 1'b1;
   // Who pulled the line is decided at the falling edge
   always @(posedge clk_i) begin
      cyc++;
      if (prev_line && !line_o) begin
         fall_cyc = cyc;
         dev_drv = dev_oe_i;
         if (dev_drv) dev_fall_q.push_back(cyc);
      end
      if (!prev_line && line_o) begin
         if (dev_drv) begin
            dev_low_q.push_back(cyc - fall_cyc);
            dev_rise = cyc;
         end else begin
            host_rise = cyc;
         end
      end
      prev_line = line_o;
   end
   // One slot: fall, hold low, release for the rest of the slot
   task automatic pulse(input int low_cyc, input int slot_cyc);
      while (cyc - dev_rise < 2100) @(negedge clk_i);
      @(negedge clk_i);
      host_low = 1'b1;
      repeat (low_cyc) @(negedge clk_i);
      host_low = 1'b0;
      repeat (slot_cyc - low_cyc) @(negedge clk_i);
   endtask
   // Even number of toggles, so the clock ends high
   task automatic scl_run(input int half_cyc, input int n);
      repeat (2 * n) begin
         repeat (half_cyc) @(negedge clk_i);
         scl_o = !scl_o;
      end
   endtask
   task automatic scl_low(input int n);
      @(negedge clk_i);
      scl_o = 1'b0;
      repeat (n) @(negedge clk_i);
      scl_o = 1'b1;
   endtask
endmodule
`default_nettype wire

// File: one_wire_host_link_tb_top.sv
// Self-checking bench for the single-wire host link timing block
`timescale 1ns/1ps
`default_nettype none
module one_wire_host_link_tb_top;
   // Short watchdog count keeps the run small; must exceed 1900
   localparam int RST_CYC = 3000;
   logic clk, rst_b, line, line_o, line_oe, scl, tx_valid, tx_bit, tx_ready;
   logic rx_valid, rx_ready, rx_ovr, link_rst, ser_rst, prev_line, prev_scl;
   one_wire_link_pkg::rx_word_t rx_word;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int ovr_cnt = 0;
   int link_cnt = 0;
   int link_at = 0;
   int ser_cnt = 0;
   int ser_at = 0;
   int line_fall_at = 0;
   int scl_fall_at = 0;

   one_wire_host_link #(.RESET_LOW_CYC(RST_CYC)) one_wire_host_link_inst (
      .SYS_CLK_I(clk), .RST_B_I(rst_b), .LINE_I(line), .LINE_O(line_o), .LINE_OE_O(line_oe),
      .SCL_I(scl), .TX_VALID_I(tx_valid), .TX_BIT_I(tx_bit), .TX_READY_O(tx_ready),
      .RX_VALID_O(rx_valid), .RX_WORD_O(rx_word), .RX_READY_I(rx_ready), .RX_OVERRUN_O(rx_ovr),
      .LINK_RESET_O(link_rst), .SERIAL_RESET_O(ser_rst));
   one_wire_host_model one_wire_host_model_inst (
      .clk_i(clk), .dev_oe_i(line_oe), .dev_o_i(line_o), .line_o(line), .scl_o(scl));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Pulses are counted where they stand, one cycle each
   always @(posedge clk) begin
      cyc++;
      if (rx_ovr === 1'b1) ovr_cnt++;
      if (link_rst === 1'b1) begin
         link_cnt++;
         link_at = cyc;
      end
      if (ser_rst === 1'b1) begin
         ser_cnt++;
         ser_at = cyc;
      end
      if (prev_line === 1'b1 && line === 1'b0) line_fall_at = cyc;
      if (prev_scl === 1'b1 && scl === 1'b0) scl_fall_at = cyc;
      prev_line = line;
      prev_scl = scl;
   end

   task automatic chk_bits(input string what, input logic [1:0] exp, input logic [1:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_range(input string what, input int lo, input int hi, input int got);
      cmp_count++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic pop(input logic [1:0] exp);
      @(negedge clk);
      chk_bits("rx valid", 2'b01, {1'b0, rx_valid});
      chk_bits("rx word", exp, rx_word);
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
   endtask

   // Break, then both ends of the one band and 860 and 1450 for zero
   task automatic t_rx_decode();
      int w[5] = '{1900, 5, 500, 860, 1450};
      logic [1:0] e[5] = '{2'b10, 2'b01, 2'b01, 2'b00, 2'b00};
      for (int i = 0; i < 5; i++) begin
         one_wire_host_model_inst.pulse(w[i], (i == 0) ? 2300 : 1900);
         pop(e[i]);
      end
   endtask
   // Third word meets a full buffer while the consumer stalls
   task automatic t_overrun();
      int o0;
      o0 = ovr_cnt;
      one_wire_host_model_inst.pulse(200, 1900);
      one_wire_host_model_inst.pulse(1000, 1900);
      one_wire_host_model_inst.pulse(200, 1900);
      chk_range("overrun pulses", o0 + 1, o0 + 1, ovr_cnt);
      pop(2'b01);
      pop(2'b00);
      chk_bits("rx empty", 2'b00, {1'b0, rx_valid});
   endtask
   // Waiting word is flushed; only the long low's break word remains
   task automatic t_link_reset();
      int l0;
      one_wire_host_model_inst.pulse(200, 1900);
      l0 = link_cnt;
      one_wire_host_model_inst.pulse(RST_CYC + 200, RST_CYC + 600);
      chk_range("link reset count", l0 + 1, l0 + 1, link_cnt);
      chk_range("link reset time", RST_CYC, RST_CYC + 10, link_at - line_fall_at);
      pop(2'b10);
      chk_bits("rx flushed", 2'b00, {1'b0, rx_valid});
   endtask
   // Two device bits back to back, offered before the response gap has run
   task automatic t_tx();
      int n0, k;
      n0 = one_wire_host_model_inst.dev_fall_q.size();
      tx_bit = 1'b1;
      tx_valid = 1'b1;
      for (int i = 0; i < 2; i++) begin
         k = 0;
         @(posedge clk);
         while (tx_ready !== 1'b1 && k < 5000) begin
            @(posedge clk);
            k++;
         end
         @(negedge clk);
         tx_bit = 1'b0;
         tx_valid = (i == 0);
      end
      repeat (2200) @(negedge clk);
      chk_range("device pulses", n0 + 2, n0 + 2, one_wire_host_model_inst.dev_fall_q.size());
      chk_range("response gap", 1900, 100000,
         one_wire_host_model_inst.dev_fall_q[n0] - one_wire_host_model_inst.host_rise);
      chk_range("one low", 320, 500, one_wire_host_model_inst.dev_low_q[n0]);
      chk_range("zero low", 800, 1450, one_wire_host_model_inst.dev_low_q[n0 + 1]);
      chk_range("device slot", 1900, 2500,
         one_wire_host_model_inst.dev_fall_q[n0 + 1] - one_wire_host_model_inst.dev_fall_q[n0]);
      chk_bits("own bits ignored", 2'b00, {1'b0, rx_valid});
   endtask
   // Legal clocking never trips the watchdog; a long low does, once
   task automatic t_serial();
      int s0;
      s0 = ser_cnt;
      one_wire_host_model_inst.scl_run(50, 20);
      one_wire_host_model_inst.scl_run(13, 20);
      chk_range("no serial reset", s0, s0, ser_cnt);
      one_wire_host_model_inst.scl_low(RST_CYC + 20);
      chk_range("serial reset count", s0 + 1, s0 + 1, ser_cnt);
      chk_range("serial reset time", RST_CYC, RST_CYC + 10, ser_at - scl_fall_at);
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      tx_valid = 1'b0;
      tx_bit = 1'b0;
      rx_ready = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      t_rx_decode();
      t_overrun();
      t_link_reset();
      t_tx();
      t_serial();
      results();
   end

   // Scenarios need about 32500 cycles
   initial begin
      repeat (80000) @(posedge clk);
      num_errors++;
      $display("ERROR watchdog expected done seen timeout");
      results();
   end
endmodule
`default_nettype wire
